// >>> bench/ltpds_printer_model.sv
// printer model: decodes serial frames and counts characters
`default_nettype none

module ltpds_printer_model #(
  parameter int BAUD_CYC = 4 // clocks per bit
) (
  input  wire logic clk,   // system clock
  input  wire logic txd,   // serial line, high is space
  output var  int   n_chr, // characters taken
  output var  int   n_bad  // frames with bad parity or stop
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;

  // sample mid-bit; a substitute printer takes any rate set here
  initial begin
    n_chr = 0;
    n_bad = 0;
    forever begin
      @(posedge clk iff txd === 1'b1);
      repeat (BAUD_CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD_CYC) @(posedge clk);
        sh[i] = txd;
      end
      repeat (BAUD_CYC) @(posedge clk);
      if ((^sh) !== 1'b0 || txd !== 1'b0) n_bad++;
      n_chr++;
    end
  end
endmodule

`default_nettype wire

// >>> bench/ltpds_top_test.sv
// self-checking bench of the dump sequencer
`default_nettype none

module ltpds_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ltpds_pkg::*;
  logic clk, arst_n, scan, kadv, kdump, kab, sv, ss, txd, rel, pen, blank;
  ltpds_mode_e mode;
  logic [13:0] loc;
  logic [15:0] sd;
  logic [7:0]  id;
  logic [9:0]  dloc;
  int n_mismatch, compares, n_chr, n_bad, cyc, c0;

  ltpds_top #(.BAUD_CYC(4), .PACE_CYC(200), .FIFO_DEPTH(8)) DUT (
    .clk(clk), .arst_n(arst_n), .mode_sel(mode), .scan_busy(scan),
    .key_adv(kadv), .key_dump(kdump), .key_abort(kab), .loc_in(loc),
    .store_valid(sv), .store_start(ss), .store_data(sd), .ser_txd(txd),
    .tape_relay(rel), .print_en(pen), .busy_blank(blank), .disp_id(id),
    .disp_loc(dloc));
  ltpds_printer_model #(.BAUD_CYC(4)) prn (.clk(clk), .txd(txd),
    .n_chr(n_chr), .n_bad(n_bad));

  task automatic end_sim();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one store strobe opening a new array, driven off the sampling edge
  task automatic store(logic [15:0] v);
    @(negedge clk) {sv, ss, sd} = {2'b11, v};
    @(negedge clk) {sv, ss} = 2'b00;
  endtask
  task automatic wait_pen(logic lv);
    for (int i = 0; i < 3000 && pen !== lv; i++) @(negedge clk);
  endtask
  // logged point is printed as one line of 17 characters
  task automatic t_print();
    c0 = n_chr;
    store(16'h1234);
    wait_pen(1'b1);
    chk("print_en", 1, pen);
    wait_pen(1'b0);
    // enable falls once the point is queued; up to eleven characters remain
    repeat (600) @(negedge clk);
    chk("chars", 17, 16'(n_chr - c0));
    chk("bad", 0, 16'(n_bad));
    chk("relay", 0, rel);
    chk("loc", 1, dloc);
  endtask
  // printer mode withholds output until logging resumes
  task automatic t_hold();
    mode = MODE_PRINT;
    store(16'h0042);
    repeat (600) @(negedge clk);
    chk("held", 0, pen);
    mode = MODE_LOG;
    wait_pen(1'b1);
    chk("resume", 1, pen);
    wait_pen(1'b0);
    // let the line drain so the sequencer is idle before the next key
    repeat (600) @(negedge clk);
  endtask
  // tape mode display, scan lockout, dump start, reset mid-dump
  task automatic t_tape();
    mode = MODE_TAPE;
    repeat (3) @(negedge clk);
    chk("id", 16'(ID_TAPE), id);
    chk("dloc", 2, dloc);
    scan = 1'b1;
    kdump = 1'b1;
    @(negedge clk) kdump = 1'b0;
    scan = 1'b0;
    chk("scan", 0, rel);
    kdump = 1'b1;
    @(negedge clk) kdump = 1'b0;
    chk("dump", 1, rel);
    chk("blank", 1, blank);
    arst_n = 1'b0;
    @(negedge clk) chk("rst", 0, {rel, blank, pen, id});
    arst_n = 1'b1;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard: ceiling well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    {arst_n, scan, kadv, kdump, kab, sv, ss} = 7'h00;
    {n_mismatch, compares, cyc} = '0;
    mode = MODE_LOG;
    loc = 14'h0000;
    sd = 16'h0000;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk) chk("reset", 0, {txd, rel, pen, blank, id});
    t_print();
    t_hold();
    t_tape();
    end_sim();
  end
endmodule

`default_nettype wire

// >>> design/ltpds_fifo.sv
// character fifo between the line formatter and the serial transmitter
`default_nettype none

module ltpds_fifo #(
  parameter int W     = 7, // word width
  parameter int DEPTH = 8  // words, power of two
) (
  input  wire logic clk,    // system clock
  input  wire logic arst_n, // asynchronous reset
  ltpds_strm_if.snk wr,     // fill side
  ltpds_strm_if.src rd      // drain side
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_ff;
  logic [AW:0]  rp_ff;
  logic         full;

  // extra pointer bit tells full from empty
  assign full = (wp_ff[AW] != rp_ff[AW]) &&
                (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = (wp_ff != rp_ff);
  assign rd.data  = mem[rp_ff[AW-1:0]];

  // storage needs no reset; pointers define what is valid
  always_ff @(posedge clk) begin
    if (wr.valid && !full) begin
      mem[wp_ff[AW-1:0]] <= wr.data;
    end
  end

  // pointers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (wr.valid && !full) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (rd.valid && rd.ready) begin
        rp_ff <= rp_ff + 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// >>> design/ltpds_pkg.sv
// constants and types shared by the tape and printer dump sequencer
`default_nettype none

package ltpds_pkg;
  localparam int          MEM_WORDS  = 608;     // final memory points
  localparam int          PTR_W      = 10;      // location width
  localparam int          LOC_W      = 14;      // keyed location width
  localparam int          DATA_W     = 16;      // stored point width
  localparam int          CHR_W      = 7;       // ascii character width
  localparam int          FIFO_DEPTH = 8;       // character buffer words
  localparam logic [9:0]  LAST_LOC   = 10'h25F; // location 607
  localparam logic [9:0]  FULL_DUMP  = 10'h260; // 608 points
  localparam logic [9:0]  TAPE_BURST = 10'h200; // 512 points
  localparam logic [2:0]  LINE_PTS_M1 = 3'h7;   // 8 points per line
  localparam logic [3:0]  CH_FIELD   = 4'h6;    // first char of a field
  localparam logic [3:0]  CH_ID_HI   = 4'h8;
  localparam logic [3:0]  CH_ID_LO   = 4'h9;
  localparam logic [3:0]  CH_COLON   = 4'hA;
  localparam logic [3:0]  CH_LAST    = 4'hE;    // 6 lead + 8 x 9 = 78
  localparam logic [6:0]  ASC_SP     = 7'h20;
  localparam logic [6:0]  ASC_COLON  = 7'h3A;
  localparam logic [6:0]  ASC_CR     = 7'h0D;
  localparam logic [6:0]  ASC_LF     = 7'h0A;
  localparam logic [6:0]  ASC_ZERO   = 7'h30;
  localparam logic [6:0]  ASC_A_M10  = 7'h37;
  localparam logic [15:0] FILL_WORD  = 16'h0000; // filler point value
  localparam logic [7:0]  ID_LOG     = 8'h00;
  localparam logic [7:0]  ID_TAPE    = 8'h08;
  localparam logic [7:0]  ID_PRINT   = 8'h09;
  localparam logic [3:0]  FRAME_BITS = 4'hB;    // 10 bits + stop hold
  localparam int          CLK_HZ     = 100_000_000;
  localparam int          BAUD       = 300;
  localparam int          PACE_MS    = 500;     // two readings per second
  localparam int          BAUD_CYC   = CLK_HZ / BAUD;
  localparam int          PACE_CYC   = (CLK_HZ / 1000) * PACE_MS;

  typedef enum logic [1:0] {
    MODE_LOG, MODE_TAPE, MODE_PRINT, MODE_OTHER
  } ltpds_mode_e;
  typedef enum logic [1:0] {
    JOB_TAPE, JOB_DUMP, JOB_FILL, JOB_PRINT
  } ltpds_job_e;
endpackage

`default_nettype wire

// >>> design/ltpds_strm_if.sv
// valid/ready character stream between the sequencer's own modules
`default_nettype none

interface ltpds_strm_if #(parameter int W = 7);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// >>> design/ltpds_top.sv
// tape and printer dump sequencer over the ring final data memory
`default_nettype none

module ltpds_top #(
  parameter int BAUD_CYC   = ltpds_pkg::BAUD_CYC,  // clocks per bit
  parameter int PACE_CYC   = ltpds_pkg::PACE_CYC,  // clocks per reading
  parameter int FIFO_DEPTH = ltpds_pkg::FIFO_DEPTH // character buffer
) (
  input  wire logic                   clk,         // 100 MHz clock
  input  wire logic                   arst_n,      // asynchronous reset
  input  wire ltpds_pkg::ltpds_mode_e mode_sel,    // keyboard mode
  input  wire logic                   scan_busy,   // measurement scan
  input  wire logic                   key_adv,     // advance key pulse
  input  wire logic                   key_dump,    // dump key pulse
  input  wire logic                   key_abort,   // abort key level
  input  wire logic [13:0]            loc_in,      // keyed location
  input  wire logic                   store_valid, // store strobe
  input  wire logic                   store_start, // point opens array
  input  wire logic [15:0]            store_data,  // point to store
  output logic                        ser_txd,     // serial data out
  output logic                        tape_relay,  // cassette relay
  output logic                        print_en,    // printer enable
  output logic                        busy_blank,  // mode digit blanked
  output logic [7:0]                  disp_id,     // id field code
  output logic [9:0]                  disp_loc     // storage pointer
);
  import ltpds_pkg::*;
  localparam int PW = $clog2(PACE_CYC + 1);

  if (PACE_CYC < 1 || FIFO_DEPTH < 2) begin : g_chk
    $error("pace or fifo depth out of range");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_SEEK, S_FETCH, S_CHAR, S_CR, S_LF, S_DRAIN
  } ltpds_st_e;

  logic [DATA_W:0]    mem [MEM_WORDS]; // bit 16 marks array start
  logic [MEM_WORDS-1:0] valid_ff;
  logic [PTR_W-1:0]   store_ptr_ff;
  logic [PTR_W-1:0]   tape_read_pointer_ff;
  logic [PTR_W-1:0]   printer_read_pointer_ff;
  logic [PTR_W-1:0]   rd_ptr_ff;
  logic [PTR_W-1:0]   left_ff;
  logic [PTR_W-1:0]   tape_fill;
  logic [PTR_W-1:0]   loc_res;
  ltpds_st_e          st_ff;
  ltpds_job_e         job_ff;
  logic [2:0]         col_ff;
  logic [3:0]         chr_ff;
  logic [7:0]         id_ff;
  logic [DATA_W-1:0]  data_ff;
  logic [PW-1:0]      pace_ff;
  logic               dump_run_ff;
  logic               tape_relay_ff;
  logic               print_en_ff;
  logic               busy_blank_ff;
  logic [7:0]         disp_id_ff;
  logic [PTR_W-1:0]   disp_loc_ff;
  logic [DATA_W:0]    mem_word;
  logic               mark_here;
  logic               is_start;
  logic               keys_ok;
  logic               idle;
  logic               in_tape;
  logic               auto_go;
  logic               flush_go;
  logic               test_go;
  logic               dump_go;
  logic               loc_go;
  logic               print_go;
  logic               push;
  logic               point_done;
  logic               seek_hit;
  logic               tx_busy;
  logic               tx_pend;
  logic [6:0]         chr_asc;
  logic [3:0]         nib;

  ltpds_strm_if #(.W(CHR_W)) fmt_s ();
  ltpds_strm_if #(.W(CHR_W)) tx_s ();

  // next location with wrap at the end of the ring
  function automatic logic [PTR_W-1:0] inc(input logic [PTR_W-1:0] p);
    inc = (p == LAST_LOC) ? '0 : p + 10'h001;
  endfunction

  function automatic logic [6:0] hex_asc(input logic [3:0] n);
    hex_asc = (n < 4'hA) ? ASC_ZERO + 7'(n) : ASC_A_M10 + 7'(n);
  endfunction

  // points stored since the last tape transfer, modulo the ring
  assign tape_fill = (store_ptr_ff >= tape_read_pointer_ff) ?
                     store_ptr_ff - tape_read_pointer_ff :
                     store_ptr_ff + FULL_DUMP - tape_read_pointer_ff;

  // keyed location: one past the pointer means oldest array
  always_comb begin
    if (loc_in == LOC_W'(store_ptr_ff) + 14'h0001) begin
      loc_res = store_ptr_ff;
    end else if (loc_in > LOC_W'(LAST_LOC)) begin
      loc_res = '0;
    end else begin
      loc_res = loc_in[PTR_W-1:0];
    end
  end

  assign mem_word  = mem[rd_ptr_ff];
  assign mark_here = valid_ff[rd_ptr_ff] && mem_word[DATA_W];
  assign is_start  = mark_here && (job_ff != JOB_FILL);

  // keyboard requests, all dropped while locked out
  assign keys_ok  = !busy_blank_ff && !scan_busy;
  assign idle     = (st_ff == S_IDLE);
  assign in_tape  = (mode_sel == MODE_TAPE);
  assign flush_go = idle && keys_ok && in_tape && key_adv &&
                    (tape_fill != '0);
  assign test_go  = idle && keys_ok && in_tape && key_adv &&
                    (tape_fill == '0);
  assign dump_go  = idle && keys_ok && in_tape && key_dump;
  assign loc_go   = idle && keys_ok && key_adv &&
                    (mode_sel == MODE_PRINT);
  // automatic transfers; tape mode takes part in neither
  assign auto_go  = idle && (mode_sel == MODE_LOG) &&
                    (tape_fill >= TAPE_BURST);
  assign print_go = idle && !auto_go && (pace_ff == '0) &&
                    (printer_read_pointer_ff != store_ptr_ff) &&
                    ((mode_sel == MODE_LOG) || dump_run_ff);

  assign push       = fmt_s.valid && fmt_s.ready;
  assign point_done = (st_ff == S_CHAR) && push && (chr_ff == CH_LAST);
  assign seek_hit   = (st_ff == S_SEEK) && mark_here;
  assign tx_pend    = tx_s.valid || tx_busy;

  // ring memory write; storing never stops, whatever the mode
  always_ff @(posedge clk) begin
    if (store_valid) begin
      mem[store_ptr_ff] <= {store_start, store_data};
    end
  end

  // storage pointer and written flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      store_ptr_ff <= '0;
      valid_ff     <= '0;
    end else if (store_valid) begin
      valid_ff[store_ptr_ff] <= 1'b1;
      store_ptr_ff           <= inc(store_ptr_ff);
    end
  end

  // formatter and transfer sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff     <= S_IDLE;
      job_ff    <= JOB_TAPE;
      rd_ptr_ff <= '0;
      left_ff   <= '0;
      col_ff    <= '0;
      chr_ff    <= '0;
      id_ff     <= '0;
      data_ff   <= '0;
    end else begin
      unique case (st_ff)
        S_IDLE: begin
          col_ff <= '0;
          if (auto_go || flush_go) begin
            job_ff    <= JOB_TAPE;
            rd_ptr_ff <= tape_read_pointer_ff;
            left_ff   <= tape_fill;
            st_ff     <= S_FETCH;
          end else if (dump_go) begin
            job_ff    <= JOB_DUMP;
            rd_ptr_ff <= store_ptr_ff; // oldest location first
            left_ff   <= FULL_DUMP;
            st_ff     <= S_FETCH;
          end else if (test_go) begin
            job_ff  <= JOB_FILL;
            left_ff <= TAPE_BURST;
            st_ff   <= S_FETCH;
          end else if (loc_go) begin
            rd_ptr_ff <= loc_res;
            left_ff   <= FULL_DUMP;
            st_ff     <= S_SEEK;
          end else if (print_go) begin
            job_ff    <= JOB_PRINT;
            rd_ptr_ff <= printer_read_pointer_ff;
            left_ff   <= 10'h001;
            st_ff     <= S_FETCH;
          end
        end
        // walk forward to the next array start, once round at most
        S_SEEK: begin
          if (mark_here || left_ff == 10'h001) begin
            st_ff <= S_IDLE;
          end else begin
            rd_ptr_ff <= inc(rd_ptr_ff);
            left_ff   <= left_ff - 10'h001;
          end
        end
        S_FETCH: begin
          if (is_start && col_ff != '0) begin
            st_ff <= S_CR; // new array opens a new line
          end else begin
            data_ff <= (job_ff == JOB_FILL) ?
                       FILL_WORD : mem_word[DATA_W-1:0];
            id_ff   <= is_start ? 8'h01 : id_ff + 8'h01;
            chr_ff  <= (col_ff == '0) ? '0 : CH_FIELD;
            st_ff   <= S_CHAR;
          end
        end
        S_CHAR: begin
          if (push && chr_ff == CH_LAST) begin
            if (job_ff != JOB_FILL) begin
              rd_ptr_ff <= inc(rd_ptr_ff);
            end
            left_ff <= left_ff - 10'h001;
            col_ff  <= col_ff + 3'h1;
            if (left_ff == 10'h001 || col_ff == LINE_PTS_M1 ||
                job_ff == JOB_PRINT) begin
              st_ff <= S_CR;
            end else begin
              st_ff <= S_FETCH;
            end
          end else if (push) begin
            chr_ff <= chr_ff + 4'h1;
          end
        end
        S_CR: begin
          if (push) begin
            col_ff <= '0;
            st_ff  <= S_LF;
          end
        end
        S_LF: begin
          if (push) begin
            st_ff <= (left_ff == '0) ? S_DRAIN : S_FETCH;
          end
        end
        // hold the relay until the last stop bit has left
        S_DRAIN: begin
          if (!tx_pend) begin
            st_ff <= S_IDLE;
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  // tape pointer follows each sent point; a full dump resyncs it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tape_read_pointer_ff <= '0;
    end else if (dump_go) begin
      tape_read_pointer_ff <= store_ptr_ff;
    end else if (point_done && job_ff == JOB_TAPE) begin
      tape_read_pointer_ff <= inc(tape_read_pointer_ff);
    end
  end

  // printer pointer and printer dump run flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      printer_read_pointer_ff <= '0;
      dump_run_ff             <= 1'b0;
    end else if (seek_hit) begin
      printer_read_pointer_ff <= rd_ptr_ff;
      dump_run_ff             <= 1'b1;
    end else begin
      if (point_done && job_ff == JOB_PRINT) begin
        printer_read_pointer_ff <= inc(printer_read_pointer_ff);
      end
      if ((key_abort && keys_ok) || mode_sel != MODE_PRINT ||
          (idle && printer_read_pointer_ff == store_ptr_ff)) begin
        dump_run_ff <= 1'b0;
      end
    end
  end

  // half-second pace between printed readings
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pace_ff <= '0;
    end else if (point_done && job_ff == JOB_PRINT) begin
      pace_ff <= PW'(PACE_CYC - 1);
    end else if (pace_ff != '0) begin
      pace_ff <= pace_ff - 1'b1;
    end
  end

  // relay spans a whole tape job; the digit is blanked only for jobs keyed in tape mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tape_relay_ff <= 1'b0;
      busy_blank_ff <= 1'b0;
    end else if (auto_go || flush_go || dump_go || test_go) begin
      tape_relay_ff <= 1'b1;
      busy_blank_ff <= in_tape;
    end else if (st_ff == S_DRAIN && !tx_pend) begin
      tape_relay_ff <= 1'b0;
      busy_blank_ff <= 1'b0;
    end
  end

  // printer enable and display fields
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      print_en_ff <= 1'b0;
      disp_id_ff  <= ID_LOG;
      disp_loc_ff <= '0;
    end else begin
      print_en_ff <= (printer_read_pointer_ff != store_ptr_ff) &&
                     ((mode_sel == MODE_LOG) || dump_run_ff);
      disp_loc_ff <= store_ptr_ff;
      unique case (mode_sel)
        MODE_TAPE:  disp_id_ff <= ID_TAPE;
        MODE_PRINT: disp_id_ff <= ID_PRINT;
        default:    disp_id_ff <= ID_LOG;
      endcase
    end
  end

  // character of the current field: lead, id, colon, four digits
  always_comb begin
    nib = data_ff[{2'(CH_LAST - chr_ff), 2'b00} +: 4];
  end

  always_comb begin
    chr_asc = ASC_SP;
    if (st_ff == S_CR) begin
      chr_asc = ASC_CR;
    end else if (st_ff == S_LF) begin
      chr_asc = ASC_LF;
    end else if (chr_ff == CH_ID_HI) begin
      chr_asc = hex_asc(id_ff[7:4]);
    end else if (chr_ff == CH_ID_LO) begin
      chr_asc = hex_asc(id_ff[3:0]);
    end else if (chr_ff == CH_COLON) begin
      chr_asc = ASC_COLON;
    end else if (chr_ff > CH_COLON) begin
      chr_asc = hex_asc(nib);
    end
  end

  // a full fifo stalls the formatter in place
  assign fmt_s.valid = (st_ff == S_CHAR) || (st_ff == S_CR) ||
                       (st_ff == S_LF);
  assign fmt_s.data  = chr_asc;

  ltpds_fifo #(.W(CHR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk    (clk),
    .arst_n (arst_n),
    .wr     (fmt_s),
    .rd     (tx_s)
  );

  ltpds_uart_tx #(.BAUD_CYC(BAUD_CYC)) u_tx (
    .clk    (clk),
    .arst_n (arst_n),
    .chr    (tx_s),
    .busy   (tx_busy),
    .txd    (ser_txd)
  );

  assign tape_relay = tape_relay_ff;
  assign print_en   = print_en_ff;
  assign busy_blank = busy_blank_ff;
  assign disp_id    = disp_id_ff;
  assign disp_loc   = disp_loc_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_auto_tape_start: assert property (
    $rose(tape_relay_ff) && $past(mode_sel) == MODE_LOG
    |-> $past(tape_fill) >= TAPE_BURST)
    else $error("tape started below burst size");
  chk_test_blank: assert property (
    test_go |=> busy_blank_ff && tape_relay_ff && job_ff == JOB_FILL)
    else $error("test dump did not blank and start");
  chk_keys_locked: assert property (
    (busy_blank_ff || scan_busy)
    |-> !(flush_go || test_go || dump_go || loc_go))
    else $error("key taken while locked");
  chk_printer_low: assert property (
    printer_read_pointer_ff == store_ptr_ff |=> !print_en_ff)
    else $error("printer enable high when caught up");
  chk_print_pace: assert property (
    point_done && job_ff == JOB_PRINT |=> !print_go [*2])
    else $error("printer readings too close");
  chk_store_wrap: assert property (
    store_valid && store_ptr_ff == LAST_LOC |=> store_ptr_ff == '0)
    else $error("storage pointer did not wrap");
  chk_print_hold: assert property (
    idle && mode_sel == MODE_PRINT && !dump_run_ff
    |=> !(st_ff == S_FETCH && job_ff == JOB_PRINT))
    else $error("printing while withheld");
  chk_line_break: assert property (
    point_done && col_ff == LINE_PTS_M1 |=> st_ff == S_CR ##0 col_ff == '0)
    else $error("line longer than eight points");
  chk_loc_clamp: assert property (
    loc_go && loc_in > 14'h025F &&
    loc_in != LOC_W'(store_ptr_ff) + 14'h0001
    |=> rd_ptr_ff == '0 && st_ff == S_SEEK)
    else $error("large location not sent to 0");
  chk_dump_size: assert property (
    dump_go |=> left_ff == FULL_DUMP && rd_ptr_ff == $past(store_ptr_ff))
    else $error("full dump not set up");
endmodule

`default_nettype wire

// >>> design/ltpds_uart_tx.sv
// asynchronous serial transmitter, 7-bit ascii with even parity
`default_nettype none

module ltpds_uart_tx #(
  parameter int BAUD_CYC = ltpds_pkg::BAUD_CYC // clocks per bit
) (
  input  wire logic clk,    // system clock
  input  wire logic arst_n, // asynchronous reset
  ltpds_strm_if.snk chr,    // characters to send
  output logic      busy,   // frame in flight
  output logic      txd     // line: low is mark, high is space
);
  import ltpds_pkg::*;
  localparam int CW = $clog2(BAUD_CYC + 1);

  if (BAUD_CYC < 2) begin : g_chk
    $error("baud divider too small");
  end

  logic [CW-1:0] cnt_ff;
  logic [9:0]    sh_ff;   // logical bits, 1 = mark
  logic [3:0]    bits_ff;
  logic          txd_ff;

  assign chr.ready = (bits_ff == '0);
  assign busy      = !chr.ready;
  assign txd       = txd_ff;

  // frame: space start, data lsb first, even parity, mark stop
  // the eleventh tick keeps the stop bit a full period long
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff  <= '0;
      sh_ff   <= '0;
      bits_ff <= '0;
      txd_ff  <= 1'b0;
    end else if (chr.valid && chr.ready) begin
      sh_ff   <= {1'b1, ^chr.data, chr.data, 1'b0};
      bits_ff <= FRAME_BITS;
      cnt_ff  <= '0;
    end else if (bits_ff != '0) begin
      if (cnt_ff == '0) begin
        txd_ff  <= ~sh_ff[0];
        sh_ff   <= {1'b1, sh_ff[9:1]};
        bits_ff <= bits_ff - 4'h1;
        cnt_ff  <= CW'(BAUD_CYC - 1);
      end else begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

`default_nettype wire
